// file: src/annunciator_consts.vh
// Constants for the field display annunciator.
// Assumes inclusion by the annunciator module only.
`ifndef ANNUNCIATOR_CONSTS_VH
`define ANNUNCIATOR_CONSTS_VH
// Clock rate and dwell time per alternation phase
`define CLK_HZ 100000000
`define DWELL_MS 1000
`define DWELL_CYCLES ((`CLK_HZ / 1000) * `DWELL_MS)
// Bar graph step, percent of span
`define BAR_STEP_PCT 10
`define BAR_SEGS 10
// Unit codes
`define UNIT_K 2'h0
`define UNIT_F 2'h1
`define UNIT_C 2'h2
`define UNIT_PCT 2'h3
// Numeric field sources
`define NUM_VALUE 2'h0
`define NUM_CODE 2'h1
`define NUM_DASH 2'h2
// Reset value of the numeric code field
`define BLANK_CODE 16'h0000
`endif

// file: src/field_display_annunciator.v
// Field display annunciator: drives the local indicator of a transmitter.
// Assumes synchronous inputs from measurement core, bus stack, switches.
//
// How it works
// - Ten percent bar steps, over/under marks
// - Fault alternates error code and dashes
// - Bar graph blanked while code shown
// - Caution lit on any fault or warning
// - Unit follows the displayed value
// - Warning alternates value and warning code
// - Error shows dashes instead of number
// - Channel text during fault or warning, else user text
// - Per-value user text names shown value
// - Communication symbol follows bus activity
// - Lock symbol follows hardware lock
// - Parameter writes only from fieldbus port
// - Switches give address and write lock
// - Lock refuses writes, status readable
`timescale 1ns/1ps
`include "annunciator_consts.vh"
module field_display_annunciator #(
  parameter VAL_W = 16,
  parameter TEXT_W = 64,
  parameter NVAL = 2,
  parameter SEL_W = 1,
  parameter DWELL = `DWELL_CYCLES
) (
  input wire clk_i,
  input wire reset_i,
  input wire [VAL_W-1:0] value_i,
  input wire [VAL_W-1:0] range_lo_i,
  input wire [VAL_W-1:0] range_hi_i,
  input wire [SEL_W-1:0] value_sel_i,
  input wire [2*NVAL-1:0] value_unit_i,
  input wire error_i,
  input wire warning_i,
  input wire [15:0] code_i,
  input wire chan_known_i,
  input wire [TEXT_W-1:0] chan_text_i,
  input wire bus_active_i,
  input wire lock_switch_i,
  input wire [6:0] addr_switch_i,
  input wire bus_wr_i,
  input wire [SEL_W-1:0] bus_wr_sel_i,
  input wire [TEXT_W-1:0] bus_wr_text_i,
  output reg [`BAR_SEGS-1:0] bar_o,
  output reg over_o,
  output reg under_o,
  output reg caution_o,
  output reg [1:0] unit_o,
  output reg [1:0] num_src_o,
  output reg [VAL_W-1:0] num_value_o,
  output reg [15:0] num_code_o,
  output reg [TEXT_W-1:0] text_o,
  output reg comm_o,
  output reg lock_o,
  output reg lock_status_o,
  output reg [6:0] bus_addr_o,
  output reg wr_refused_o
);
  // Alternation states, one-hot
  localparam [2:0] ST_VALUE = 3'b001; // No condition, value only
  localparam [2:0] ST_CODE = 3'b010; // Condition, code phase
  localparam [2:0] ST_SHOW = 3'b100; // Condition, value phase
  // Last count of one dwell phase
  localparam [31:0] DWELL_LAST = DWELL - 1;
  // Number of bar segments
  localparam SEGS = `BAR_SEGS;

  // Condition summary
  wire cond;
  // Range arithmetic
  wire [VAL_W-1:0] span;
  wire [VAL_W-1:0] offset;
  wire [VAL_W+3:0] rel10;
  wire in_over;
  wire in_under;
  // Text store, all entries side by side
  wire [NVAL*TEXT_W-1:0] text_flat;
  wire [TEXT_W-1:0] user_text;
  wire [1:0] shown_unit;
  // Alternation control
  reg [2:0] state;
  reg [2:0] next_state;
  reg [31:0] dwell_cnt;
  wire dwell_done;
  wire show_code;
  // Next values of the display registers
  wire [SEGS-1:0] next_bar;
  reg [1:0] next_num_src;
  reg [TEXT_W-1:0] next_text;
  genvar e;
  genvar s;

  // Any fault or warning present
  assign cond = error_i | warning_i;

  // Distance into the range, scaled by ten
  assign span = range_hi_i - range_lo_i;
  assign offset = value_i - range_lo_i;
  assign rel10 = {4'h0, offset} * 4'd10;
  // Out of range on either side
  assign in_over = value_i > range_hi_i;
  assign in_under = value_i < range_lo_i;

  // One user text entry per displayable value
  generate
    for (e = 0; e < NVAL; e = e + 1) begin : g_text
      localparam [SEL_W-1:0] ENTRY = e;
      reg [TEXT_W-1:0] entry;
      wire take;
      assign take = bus_wr_i && !lock_switch_i && bus_wr_sel_i == ENTRY;
      // Entry keeps its text until rewritten
      always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          entry <= {TEXT_W{1'b0}};
        end else if (take) begin
          entry <= bus_wr_text_i;
        end
      end
      assign text_flat[e*TEXT_W +: TEXT_W] = entry;
    end
  endgenerate

  // Text of the value now selected
  assign user_text = text_flat[value_sel_i*TEXT_W +: TEXT_W];
  // Unit of the value now selected
  assign shown_unit = value_unit_i[value_sel_i*2 +: 2];

  // Dwell counter, cleared on every phase change
  assign dwell_done = dwell_cnt >= DWELL_LAST;
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      dwell_cnt <= 32'h0000_0000;
    end else if (state == ST_VALUE || !cond || dwell_done) begin
      dwell_cnt <= 32'h0000_0000;
    end else begin
      dwell_cnt <= dwell_cnt + 32'h0000_0001;
    end
  end

  // Alternation state register
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= ST_VALUE;
    end else begin
      state <= next_state;
    end
  end

  // Code first, then value, one dwell each
  always @* begin
    next_state = state;
    case (state)
      ST_VALUE: begin
        // A new condition shows its code at once
        if (cond) begin
          next_state = ST_CODE;
        end
      end
      ST_CODE: begin
        if (!cond) begin
          next_state = ST_VALUE;
        end else if (dwell_done) begin
          next_state = ST_SHOW;
        end
      end
      ST_SHOW: begin
        if (!cond) begin
          next_state = ST_VALUE;
        end else if (dwell_done) begin
          next_state = ST_CODE;
        end
      end
      default: begin
        // Lost state: fall back to value display
        next_state = ST_VALUE;
      end
    endcase
  end

  // Code phase of the alternation
  assign show_code = state == ST_CODE;

  // One segment per tenth of span
  generate
    for (s = 0; s < SEGS; s = s + 1) begin : g_seg
      localparam [3:0] SEG_NO = s + 1;
      wire [VAL_W+3:0] thresh;
      // Segment lights at its tenth of span
      assign thresh = {4'h0, span} * SEG_NO;
      // Dark while the code is shown
      assign next_bar[s] = !show_code && !in_under &&
                           (in_over || rel10 >= thresh);
    end
  endgenerate

  always @* begin
    next_num_src = `NUM_VALUE;
    if (show_code) begin
      next_num_src = `NUM_CODE;
    end else if (error_i) begin
      // Dashes stand in for the number
      next_num_src = `NUM_DASH;
    end
  end

  // Channel text in fault or warning, else user text
  always @* begin
    next_text = user_text;
    if (cond) begin
      // Blank when the channel is unknown
      if (chan_known_i) begin
        next_text = chan_text_i;
      end else begin
        next_text = {TEXT_W{1'b0}};
      end
    end
  end

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      bar_o <= {SEGS{1'b0}};
      over_o <= 1'b0;
      under_o <= 1'b0;
    end else begin
      bar_o <= next_bar;
      // Marks share the bar's blanking
      over_o <= !show_code && in_over;
      under_o <= !show_code && in_under;
    end
  end

  // Caution on any fault or warning
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      caution_o <= 1'b0;
    end else begin
      caution_o <= cond;
    end
  end

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      unit_o <= `UNIT_K;
    end else begin
      unit_o <= shown_unit;
    end
  end

  // Numeric field: source, value and code
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      num_src_o <= `NUM_VALUE;
      num_value_o <= {VAL_W{1'b0}};
      num_code_o <= `BLANK_CODE;
    end else begin
      num_src_o <= next_num_src;
      num_value_o <= value_i;
      num_code_o <= code_i;
    end
  end

  // Status text field
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      text_o <= {TEXT_W{1'b0}};
    end else begin
      text_o <= next_text;
    end
  end

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      comm_o <= 1'b0;
    end else begin
      comm_o <= bus_active_i;
    end
  end

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      lock_o <= 1'b0;
    end else begin
      lock_o <= lock_switch_i;
    end
  end

  // Switch readback: address and lock state
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      lock_status_o <= 1'b0;
      bus_addr_o <= 7'h00;
    end else begin
      lock_status_o <= lock_switch_i;
      bus_addr_o <= addr_switch_i;
    end
  end

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_refused_o <= 1'b0;
    end else begin
      wr_refused_o <= bus_wr_i && lock_switch_i;
    end
  end
endmodule // field_display_annunciator

// file: tb/fda_side.sv
// Far side: span 100..1100 and bus activity.
// Assumes the bench clock.
`timescale 1ns/1ps
module fda_side (
  input wire clk_i,
  output wire [31:0] span_o,
  output wire act_o
);
  reg [3:0] n = 4'h0;
  assign span_o = 32'h044c_0064;
  assign act_o = n[3];
  // Bus busy in bursts of eight cycles
  always @(posedge clk_i) n <= n + 4'h1;
endmodule // fda_side

// file: tb/fda_chk.sv
// Assertions on the annunciator ports.
// Assumes the bind at the foot.
`timescale 1ns/1ps
module fda_chk (
  input wire clk_i, reset_i, error_i, warning_i, bus_active_i,
  input wire lock_switch_i, bus_wr_i, caution_o, comm_o, lock_o,
  input wire wr_refused_o,
  input wire [9:0] bar_o,
  input wire [1:0] num_src_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Fresh warning held with no error
  sequence s_warn;
    !(warning_i || error_i) ##1 (warning_i && !error_i)[*4];
  endsequence
  a_caution_lit: assert property (1 |=> caution_o ==
    $past(error_i | warning_i)) else $error("caution");
  a_comm_lit: assert property (1 |=> comm_o ==
    $past(bus_active_i)) else $error("comm");
  a_lock_lit: assert property (1 |=> lock_o ==
    $past(lock_switch_i)) else $error("lock");
  a_write_refused: assert property (bus_wr_i && lock_switch_i |=>
    wr_refused_o) else $error("refuse");
  a_refuse_cause: assert property (wr_refused_o |->
    $past(bus_wr_i && lock_switch_i)) else $error("cause");
  a_bar_blank: assert property (num_src_o == 2'h1 |->
    bar_o == 10'h000) else $error("bar");
  a_dash_error: assert property (num_src_o == 2'h2 |->
    $past(error_i)) else $error("dash");
  a_code_first: assert property (s_warn |-> ##[0:2]
    num_src_o == 2'h1) else $error("code");
endmodule // fda_chk
bind field_display_annunciator fda_chk i_fda_chk (.*);

// file: tb/field_display_annunciator_tb.sv
// Bench for the annunciator, dwell cut to 8 cycles.
// Assumes the far-side model and the bound checker.
`timescale 1ns/1ps
module field_display_annunciator_tb;
  reg clk_i = 1'b0, reset_i = 1'b1, error_i, warning_i, chan_known_i;
  reg lock_switch_i, bus_wr_i, value_sel_i, bus_wr_sel_i;
  reg [3:0] value_unit_i;
  reg [6:0] addr_switch_i;
  reg [15:0] value_i, code_i;
  reg [63:0] chan_text_i, bus_wr_text_i;
  reg [31:0] r = 32'h0000_6e97;
  wire bus_active_i, over_o, under_o, caution_o, comm_o, lock_o;
  wire lock_status_o, wr_refused_o;
  wire [1:0] unit_o, num_src_o;
  wire [6:0] bus_addr_o;
  wire [9:0] bar_o;
  wire [15:0] range_lo_i, range_hi_i, num_value_o, num_code_o;
  wire [63:0] text_o;
  integer failures = 0, tests_run = 0, i, seen;
  field_display_annunciator #(.DWELL(8)) i_field_display_annunciator (.*);
  fda_side i_fda_side (.clk_i, .span_o({range_hi_i, range_lo_i}),
    .act_o(bus_active_i));
  // Clock, and a guard far past the run of some 515 cycles
  initial forever #5 clk_i = ~clk_i;
  initial begin
    #100000 failures = failures + 1;
    complete_run;
  end
  function [31:0] xs(input [31:0] s);
    xs = s ^ (s << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  // One lit segment per 100 counts above the range low end
  function [9:0] bar_of(input [15:0] v);
    bar_of = (10'h001 << ((v - 16'h0064) / 100)) - 10'h001;
  endfunction
  task chk(input [63:0] e, g, input [31:0] n);
    tests_run = tests_run + 1;
    if (e !== g) begin
      failures = failures + 1;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task step(input integer n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task complete_run;
    if (failures == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    {error_i, warning_i, chan_known_i, lock_switch_i, bus_wr_i} = 5'h00;
    {value_sel_i, bus_wr_sel_i, value_unit_i, addr_switch_i} = 13'h0000;
    {value_i, code_i, chan_text_i, bus_wr_text_i} = 160'h0;
    step(12);
    reset_i = 1'b0;
    // Random faults, lock, writes and switches
    repeat (400) begin
      chk(addr_switch_i, bus_addr_o, "addr");
      r = xs(r);
      {error_i, warning_i, lock_switch_i, bus_wr_i} = r[3:0];
      {addr_switch_i, value_i, bus_wr_text_i} = {r[31:9], r, r};
      step(1);
    end
    // Text stored, locked write refused, bar at 45 percent
    {error_i, warning_i, lock_switch_i, bus_wr_i} = 4'h1;
    {value_i, bus_wr_text_i} = {16'h0226, 64'h5445_4d50};
    step(1);
    {lock_switch_i, bus_wr_text_i} = {1'b1, 64'h0};
    step(1);
    chk(1, lock_status_o, "lsts");
    {lock_switch_i, bus_wr_sel_i, bus_wr_text_i} = {2'h1, 64'h4f55_5431};
    step(1);
    bus_wr_i = 1'b0;
    step(2);
    chk(64'h5445_4d50, text_o, "text");
    chk(bar_of(value_i), bar_o, "bar");
    value_sel_i = 1'b1;
    step(2);
    chk(64'h4f55_5431, text_o, "txt1");
    value_sel_i = 1'b0;
    // Under and over range marks
    value_i = 16'h0032;
    step(2);
    chk(12'h001, {bar_o, over_o, under_o}, "undr");
    value_i = 16'h07d0;
    step(2);
    chk(12'hffe, {bar_o, over_o, under_o}, "over");
    // Every unit code, entries 0 and 1 taken in turn
    for (i = 0; i < 4; i = i + 1) begin
      value_unit_i = i * 5;
      value_sel_i = i;
      step(2);
      chk(i, unit_o, "unit");
    end
    value_sel_i = 1'b0;
    // Warning with channel text, then error without
    {code_i, chan_text_i} = {16'h0103, 64'h4348_3120};
    for (i = 0; i < 2; i = i + 1) begin
      {error_i, warning_i, chan_known_i} = i ? 3'h4 : 3'h3;
      seen = 0;
      repeat (40) begin
        step(1);
        seen = seen | (1 << num_src_o);
      end
      chk(i ? 6 : 3, seen, "alt");
      chk(i ? 0 : 64'h4348_3120, text_o, "chan");
      chk(code_i, num_code_o, "code");
      chk(value_i, num_value_o, "nval");
      {error_i, warning_i} = 2'h0;
      step(2);
      chk(0, num_src_o, "src");
    end
    complete_run;
  end
endmodule // field_display_annunciator_tb
